/* File: verilog/status_bank.v */
// status register bank of a serial flash, with its serial command front end
`include "status_bank_consts.vh"

module status_bank (
    // clock and reset
    input wire clk,
    input wire reset,
    // serial pins
    input wire sclk,
    input wire cs_n,
    input wire si,
    output reg so_out,
    output reg so_oe,
    // array engine
    input wire array_busy,
    input wire array_erasing,
    output reg program_start,
    output reg erase_start,
    output reg chip_erase_start,
    output reg suspend_req,
    output reg resume_req,
    // status and configuration
    output reg busy_flag,
    output reg write_permit_latch,
    output reg [4:0] region_guard,
    output reg invert_guard,
    output reg [2:0] secure_area_lock,
    output reg four_line_enable,
    output reg erase_paused,
    output reg program_paused,
    output reg [3:0] dual_wait_cycles,
    output reg [3:0] quad_wait_cycles,
    output reg [2:0] drive_quarters
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    reg sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
    reg cs_s1_reg, cs_s2_reg, cs_d_reg;
    reg si_s1_reg, si_s2_reg;

    always @(posedge clk) begin
        if (reset) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            si_s1_reg <= 1'b0;
            si_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_d_reg <= sclk_s2_reg;
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_d_reg <= cs_s2_reg;
            si_s1_reg <= si;
            si_s2_reg <= si_s1_reg;
        end
    end

    wire selected = ~cs_s2_reg;
    wire sclk_rise = selected & sclk_s2_reg & ~sclk_d_reg;
    wire sclk_fall = selected & ~sclk_s2_reg & sclk_d_reg;
    wire cs_rise = cs_s2_reg & ~cs_d_reg;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [2:0] bit_cnt_reg;
    reg [2:0] byte_cnt_reg;
    reg [7:0] shift_in_reg;
    reg [7:0] cmd_reg;
    reg [7:0] data_reg;
    reg [7:0] shift_out_reg;
    reg reading_reg;
    reg reset_armed_reg;
    reg lockdown_low_reg;
    reg lockdown_high_reg;
    reg wait_select_reg;
    reg [1:0] strength_reg;
    reg [15:0] sr_timer_reg;
    reg array_busy_d_reg;

    wire [7:0] byte_in = {shift_in_reg[6:0], si_s2_reg};
    wire busy_now = array_busy | (sr_timer_reg != 16'h0000);
    wire boundary = (bit_cnt_reg == 3'h0);
    wire array_done = array_busy_d_reg & ~array_busy;

    function [7:0] sr_image;
        input [7:0] cmd;
        begin
            case (cmd)
                `CMD_READ_SR2: sr_image = {erase_paused, invert_guard,
                    secure_area_lock, program_paused, 1'b1,
                    lockdown_high_reg};
                `CMD_READ_SR3: sr_image = {1'b0, strength_reg,
                    4'h0, wait_select_reg};
                default: sr_image = {lockdown_low_reg, region_guard,
                    write_permit_latch, busy_flag};
            endcase
        end
    endfunction

    function is_read;
        input [7:0] cmd;
        begin
            is_read = (cmd == `CMD_READ_SR1) | (cmd == `CMD_READ_SR2) |
                (cmd == `CMD_READ_SR3);
        end
    endfunction

    wire [7:0] image_now = sr_image(cmd_reg);

    // execution decode at chip select release
    wire exec = cs_rise & boundary & (byte_cnt_reg != 3'h0);
    wire len1 = byte_cnt_reg == `LEN_SHORT;
    wire permit = write_permit_latch & ~busy_now;
    wire sr_open = ~lockdown_high_reg;
    wire is_sr_write = (cmd_reg == `CMD_WRITE_SR1) |
        (cmd_reg == `CMD_WRITE_SR2) | (cmd_reg == `CMD_WRITE_SR3);
    wire do_sr_write = exec & is_sr_write &
        (byte_cnt_reg == `LEN_SR_WRITE) & permit & sr_open;
    wire do_program = exec & permit & (byte_cnt_reg >= `LEN_PAGE_MIN) &
        ((cmd_reg == `CMD_PAGE_WRITE) | (cmd_reg == `CMD_QUAD_PAGE_WRITE));
    wire do_erase = exec & permit & (byte_cnt_reg == `LEN_WIPE) &
        ((cmd_reg == `CMD_SMALL_WIPE) | (cmd_reg == `CMD_BLOCK_WIPE_32K) |
        (cmd_reg == `CMD_BLOCK_WIPE_64K));
    wire chip_ok = (region_guard[2:0] == 3'h0 & ~invert_guard) |
        (region_guard[2:0] == 3'h7 & invert_guard);
    wire do_chip = exec & permit & len1 & chip_ok &
        ((cmd_reg == `CMD_CHIP_WIPE_A) | (cmd_reg == `CMD_CHIP_WIPE_B));
    wire do_suspend = exec & len1 & (cmd_reg == `CMD_SUSPEND) & array_busy;
    wire do_resume = exec & len1 & (cmd_reg == `CMD_RESUME);
    wire do_sw_reset = exec & len1 & (cmd_reg == `CMD_RESET_GO) &
        reset_armed_reg;

    // ---------------------------------------------------------------
    // serial shifter
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (reset | ~selected) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            shift_in_reg <= 8'h00;
            reading_reg <= 1'b0;
            so_out <= 1'b0;
            so_oe <= 1'b0;
            shift_out_reg <= 8'h00;
            if (reset) begin
                cmd_reg <= 8'h00;
                data_reg <= 8'h00;
            end
        end else begin
            if (sclk_rise) begin
                shift_in_reg <= byte_in;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    if (byte_cnt_reg != 3'h7)
                        byte_cnt_reg <= byte_cnt_reg + 3'h1;
                    if (byte_cnt_reg == 3'h0) begin
                        cmd_reg <= byte_in;
                        if (is_read(byte_in)) begin
                            reading_reg <= 1'b1;
                            shift_out_reg <= sr_image(byte_in);
                        end
                    end else if (byte_cnt_reg == 3'h1) begin
                        data_reg <= byte_in;
                    end
                end
            end
            // mode 0: data changes on the falling edge, msb first
            // each byte boundary reloads a fresh image, so a long read
            // follows the live bits instead of a stale copy
            if (sclk_fall & reading_reg) begin
                so_oe <= 1'b1;
                if (bit_cnt_reg == 3'h0) begin
                    so_out <= image_now[7];
                    shift_out_reg <= {image_now[6:0], 1'b0};
                end else begin
                    so_out <= shift_out_reg[7];
                    shift_out_reg <= {shift_out_reg[6:0], 1'b0};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    // reset stands for a power cycle: volatile bits, lockdown and the
    // factory defaults return; one-time bits cannot outlive it here
    always @(posedge clk) begin
        if (reset) begin
            write_permit_latch <= 1'b0;
            lockdown_low_reg <= 1'b0;
            lockdown_high_reg <= 1'b0;
            region_guard <= `GUARD_RESET;
            invert_guard <= 1'b0;
            secure_area_lock <= `LOCK_RESET;
            erase_paused <= 1'b0;
            program_paused <= 1'b0;
            wait_select_reg <= 1'b0;
            strength_reg <= `STRENGTH_RESET;
            reset_armed_reg <= 1'b0;
            sr_timer_reg <= 16'h0000;
            array_busy_d_reg <= 1'b0;
        end else begin
            array_busy_d_reg <= array_busy;
            if (sr_timer_reg != 16'h0000)
                sr_timer_reg <= sr_timer_reg - 16'h0001;
            if (exec)
                reset_armed_reg <= len1 & (cmd_reg == `CMD_RESET_ARM);
            // latch: clear events are ordered before the set
            if ((sr_timer_reg == 16'h0001) | array_done |
                (exec & len1 & (cmd_reg == `CMD_WRITE_DISABLE)) |
                do_sw_reset)
                write_permit_latch <= 1'b0;
            if (exec & len1 & (cmd_reg == `CMD_WRITE_ENABLE))
                write_permit_latch <= 1'b1;
            if (do_sr_write) begin
                sr_timer_reg <= `SR_WRITE_CYCLES;
                case (cmd_reg)
                    `CMD_WRITE_SR1: begin
                        lockdown_low_reg <= data_reg[`SR1_LOCKDOWN_LOW];
                        region_guard <=
                            data_reg[`SR1_GUARD_HI:`SR1_GUARD_LO];
                    end
                    `CMD_WRITE_SR2: begin
                        invert_guard <= data_reg[`SR2_INVERT];
                        secure_area_lock <= secure_area_lock |
                            data_reg[`SR2_LOCK_HI:`SR2_LOCK_LO];
                        lockdown_high_reg <=
                            data_reg[`SR2_LOCKDOWN_HIGH];
                    end
                    default: begin
                        // reserved bits are dropped and read as zero
                        strength_reg <= data_reg[
                            `SR3_STRENGTH_HI:`SR3_STRENGTH_LO];
                        wait_select_reg <= data_reg[`SR3_WAIT_SEL];
                    end
                endcase
            end
            if (do_resume | do_sw_reset) begin
                erase_paused <= 1'b0;
                program_paused <= 1'b0;
            end
            if (do_suspend) begin
                if (array_erasing)
                    erase_paused <= 1'b1;
                else
                    program_paused <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            busy_flag <= 1'b0;
            program_start <= 1'b0;
            erase_start <= 1'b0;
            chip_erase_start <= 1'b0;
            suspend_req <= 1'b0;
            resume_req <= 1'b0;
            four_line_enable <= 1'b1;
            dual_wait_cycles <= `DUAL_WAIT_SHORT;
            quad_wait_cycles <= `QUAD_WAIT_SHORT;
            drive_quarters <= 3'h3;
        end else begin
            busy_flag <= busy_now | do_sr_write | do_program | do_erase |
                do_chip;
            program_start <= do_program;
            erase_start <= do_erase;
            chip_erase_start <= do_chip;
            suspend_req <= do_suspend;
            resume_req <= do_resume;
            four_line_enable <= 1'b1;
            dual_wait_cycles <= wait_select_reg ? `DUAL_WAIT_LONG :
                `DUAL_WAIT_SHORT;
            quad_wait_cycles <= wait_select_reg ? `QUAD_WAIT_LONG :
                `QUAD_WAIT_SHORT;
            case (strength_reg)
                2'h0: drive_quarters <= 3'h4;
                2'h1: drive_quarters <= 3'h3;
                2'h2: drive_quarters <= 3'h2;
                default: drive_quarters <= 3'h1;
            endcase
        end
    end

endmodule

/* File: verilog/status_bank_consts.vh */
// constants for the serial flash status register bank
`ifndef STATUS_BANK_CONSTS_VH
`define STATUS_BANK_CONSTS_VH

// command codes
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_SR1 8'h05
`define CMD_READ_SR2 8'h35
`define CMD_READ_SR3 8'h15
`define CMD_WRITE_SR1 8'h01
`define CMD_WRITE_SR2 8'h31
`define CMD_WRITE_SR3 8'h11
`define CMD_PAGE_WRITE 8'h02
`define CMD_QUAD_PAGE_WRITE 8'h32
`define CMD_SMALL_WIPE 8'h20
`define CMD_BLOCK_WIPE_32K 8'h52
`define CMD_BLOCK_WIPE_64K 8'hD8
`define CMD_CHIP_WIPE_A 8'h60
`define CMD_CHIP_WIPE_B 8'hC7
`define CMD_SUSPEND 8'h75
`define CMD_RESUME 8'h7A
`define CMD_RESET_ARM 8'h66
`define CMD_RESET_GO 8'h99

// bytes a command must carry before chip select rises
`define LEN_SHORT 3'h1
`define LEN_SR_WRITE 3'h2
`define LEN_WIPE 3'h4
`define LEN_PAGE_MIN 3'h5

// first status register field positions
`define SR1_LOCKDOWN_LOW 7
`define SR1_GUARD_HI 6
`define SR1_GUARD_LO 2
// second status register field positions
`define SR2_INVERT 6
`define SR2_LOCK_HI 5
`define SR2_LOCK_LO 3
`define SR2_LOCKDOWN_HIGH 0
// third status register field positions
`define SR3_STRENGTH_HI 6
`define SR3_STRENGTH_LO 5
`define SR3_WAIT_SEL 0

// reset values
`define GUARD_RESET 5'h00
`define LOCK_RESET 3'h0
`define STRENGTH_RESET 2'h1

// dummy cycle counts
`define DUAL_WAIT_SHORT 4'h4
`define DUAL_WAIT_LONG 4'h8
`define QUAD_WAIT_SHORT 4'h6
`define QUAD_WAIT_LONG 4'hA

// status write busy time: 2 us at 5 ns per cycle, sized for the timer
`define SR_WRITE_CYCLES 16'h0190

`endif

/* File: verification/status_bank_checker.sv */
// assertion checker for the status register bank
module status_bank_checker (
    // clock and reset
    input wire clk,
    input wire reset,
    // pins and array engine
    input wire cs_n,
    input wire so_oe,
    input wire array_busy,
    input wire chip_erase_start,
    input wire program_start,
    input wire erase_start,
    input wire resume_req,
    // status outputs
    input wire busy_flag,
    input wire write_permit_latch,
    input wire [4:0] region_guard,
    input wire invert_guard,
    input wire [2:0] secure_area_lock,
    input wire four_line_enable,
    input wire erase_paused,
    input wire program_paused,
    input wire [3:0] dual_wait_cycles,
    input wire [3:0] quad_wait_cycles,
    input wire [2:0] drive_quarters
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    four_line_a: assert property (four_line_enable)
        else $error("four-line bit not one");
    wait_pair_a: assert property ((dual_wait_cycles == 4'h4 &&
        quad_wait_cycles == 4'h6) || (dual_wait_cycles == 4'h8 &&
        quad_wait_cycles == 4'hA)) else $error("wait counts mismatch");
    strength_range_a: assert property (drive_quarters >= 3'h1 &&
        drive_quarters <= 3'h4) else $error("strength out of range");
    lock_sticky_a: assert property ((secure_area_lock &
        $past(secure_area_lock)) == $past(secure_area_lock))
        else $error("lock bit cleared");
    guard_quiet_a: assert property (!$stable(region_guard) |-> cs_n)
        else $error("guard changed while selected");
    start_permit_a: assert property ((program_start || erase_start ||
        chip_erase_start) |-> write_permit_latch)
        else $error("array start without latch");
    chip_wipe_a: assert property (chip_erase_start |->
        (region_guard[2:0] == 3'h0 && !invert_guard) ||
        (region_guard[2:0] == 3'h7 && invert_guard))
        else $error("chip wipe with guards set");
    busy_follow_a: assert property (array_busy [*3] |-> busy_flag)
        else $error("busy flag low during array work");
    resume_clear_a: assert property (resume_req |->
        ##[0:2] (!erase_paused && !program_paused))
        else $error("paused flags not cleared");
    oe_release_a: assert property (cs_n [*6] |-> !so_oe)
        else $error("output enabled while deselected");
endmodule

bind status_bank status_bank_checker i_checker (
    .clk(clk), .reset(reset), .cs_n(cs_n), .so_oe(so_oe),
    .array_busy(array_busy), .chip_erase_start(chip_erase_start),
    .program_start(program_start), .erase_start(erase_start),
    .resume_req(resume_req), .busy_flag(busy_flag),
    .write_permit_latch(write_permit_latch), .region_guard(region_guard),
    .invert_guard(invert_guard), .secure_area_lock(secure_area_lock),
    .four_line_enable(four_line_enable), .erase_paused(erase_paused),
    .program_paused(program_paused), .dual_wait_cycles(dual_wait_cycles),
    .quad_wait_cycles(quad_wait_cycles), .drive_quarters(drive_quarters)
);

/* File: verification/spi_host_model.sv */
// serial host controller model driving the flash command pins
module spi_host_model (
    // clock
    input wire clk,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire so_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // mode 0, levels held 4 clocks so the pin synchroniser sees each one
    task automatic xfer(input logic [15:0] data, input int nbits,
                        output logic [7:0] rd);
        xfer_long({data, 24'h000000}, nbits, rd);
    endtask
    // up to five bytes, left aligned, for address-carrying commands
    task automatic xfer_long(input logic [39:0] data, input int nbits,
                             output logic [7:0] rd);
        rd = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si = data[39 - i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            if (i >= 8) rd = {rd[6:0], so_out};
            sclk = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        si = ~si;
        tick(14);
    endtask
endmodule

/* File: verification/status_bank_tb_top.sv */
// self-checking testbench for the status register bank
module status_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, sclk, cs_n, si, so_out, so_oe, array_busy, array_erasing;
    logic program_start, erase_start, chip_erase_start, suspend_req;
    logic resume_req, busy_flag, write_permit_latch, invert_guard;
    logic four_line_enable, erase_paused, program_paused;
    logic [4:0] region_guard;
    logic [2:0] secure_area_lock, drive_quarters;
    logic [3:0] dual_wait_cycles, quad_wait_cycles;
    logic [7:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    int wipes = 0;
    int pauses = 0;
    int programs = 0;
    int erases = 0;
    status_bank i_dut (
        .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so_out(so_out), .so_oe(so_oe), .array_busy(array_busy),
        .array_erasing(array_erasing), .program_start(program_start),
        .erase_start(erase_start), .chip_erase_start(chip_erase_start),
        .suspend_req(suspend_req), .resume_req(resume_req),
        .busy_flag(busy_flag), .write_permit_latch(write_permit_latch),
        .region_guard(region_guard), .invert_guard(invert_guard),
        .secure_area_lock(secure_area_lock),
        .four_line_enable(four_line_enable), .erase_paused(erase_paused),
        .program_paused(program_paused),
        .dual_wait_cycles(dual_wait_cycles),
        .quad_wait_cycles(quad_wait_cycles), .drive_quarters(drive_quarters)
    );
    spi_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so_out(so_out));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (chip_erase_start === 1'b1) wipes++;
        if (suspend_req === 1'b1) pauses++;
        if (program_start === 1'b1) programs++;
        if (erase_start === 1'b1) erases++;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        i_host.xfer({c, 8'h00}, 8, rd);
    endtask
    task automatic rd_sr(input logic [7:0] c);
        i_host.xfer({c, 8'h00}, 16, rd);
    endtask
    // refused writes never raise busy, so the wait ends at once
    task automatic wr_sr(input logic [7:0] c, input logic [7:0] d);
        cmd(8'h06);
        i_host.xfer({c, d}, 16, rd);
        for (int n = 0; n < 600 && busy_flag !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        check({7'h0, busy_flag}, 8'h00);
    endtask
    task automatic do_reset(input int n);
        reset = 1'b1;
        repeat (n) @(posedge clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        check({1'b0, drive_quarters, dual_wait_cycles}, 8'h34);
        check({4'h0, quad_wait_cycles}, 8'h06);
        check({secure_area_lock, four_line_enable, erase_paused,
               program_paused, invert_guard, busy_flag}, 8'h10);
        rd_sr(8'h05);
        check(rd, 8'h00);
        rd_sr(8'h35);
        check(rd, 8'h02);
        rd_sr(8'h15);
        check(rd, 8'h20);
    endtask
    task automatic t_guard_write();
        i_host.xfer({8'h01, 8'h1C}, 16, rd);
        check({3'h0, region_guard}, 8'h00);
        cmd(8'h06);
        check({7'h0, write_permit_latch}, 8'h01);
        i_host.xfer({8'h01, 8'h1C}, 16, rd);
        check({7'h0, busy_flag}, 8'h01);
        wr_sr(8'h05, 8'h00);
        check({busy_flag, write_permit_latch, 1'b0, region_guard},
              8'h07);
        rd_sr(8'h05);
        check(rd, 8'h1C);
        cmd(8'h06);
        i_host.xfer({8'h01, 8'h00}, 12, rd);
        check({write_permit_latch, 2'h0, region_guard}, 8'h87);
        cmd(8'h04);
        check({7'h0, write_permit_latch}, 8'h00);
    endtask
    task automatic t_config();
        for (int c = 0; c < 4; c++) begin
            wr_sr(8'h11, {1'b0, c[1:0], 4'h0, c[0]});
            check({5'h0, drive_quarters}, 8'(4 - c));
            check({dual_wait_cycles, quad_wait_cycles},
                  c[0] ? 8'h8A : 8'h46);
            rd_sr(8'h15);
            check(rd, {1'b0, c[1:0], 4'h0, c[0]});
        end
        wr_sr(8'h31, 8'h48);
        wr_sr(8'h31, 8'h00);
        check({3'h0, secure_area_lock, invert_guard, four_line_enable},
              8'h05);
    endtask
    task automatic t_array();
        cmd(8'h06);
        cmd(8'h60);
        check(8'(wipes), 8'h00);
        wr_sr(8'h31, 8'h40);
        cmd(8'h06);
        cmd(8'hC7);
        check(8'(wipes), 8'h01);
        array_busy = 1'b1;
        array_erasing = 1'b1;
        cmd(8'h75);
        check({pauses[3:0], erase_paused, program_paused, 2'h0},
              8'h18);
        array_busy = 1'b0;
        cmd(8'h7A);
        check({6'h0, erase_paused, write_permit_latch}, 8'h00);
        array_busy = 1'b1;
        array_erasing = 1'b0;
        cmd(8'h75);
        check({6'h0, erase_paused, program_paused}, 8'h01);
        array_busy = 1'b0;
        cmd(8'h66);
        cmd(8'h99);
        check({7'h0, program_paused}, 8'h00);
    endtask
    task automatic t_program();
        i_host.xfer_long({8'h02, 32'h00000000}, 40, rd);
        check(8'(programs), 8'h00);
        cmd(8'h06);
        i_host.xfer_long({8'h02, 32'h00000000}, 40, rd);
        check(8'(programs), 8'h01);
        array_busy = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({6'h0, busy_flag, write_permit_latch}, 8'h03);
        array_busy = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check({6'h0, busy_flag, write_permit_latch}, 8'h00);
        cmd(8'h06);
        i_host.xfer_long({8'h20, 32'h00000000}, 28, rd);
        check(8'(erases), 8'h00);
        i_host.xfer_long({8'h20, 32'h00000000}, 32, rd);
        check({programs[3:0], erases[3:0]}, 8'h11);
    endtask
    task automatic t_lockdown();
        wr_sr(8'h31, 8'h01);
        wr_sr(8'h01, 8'h00);
        check({3'h0, region_guard}, 8'h07);
        do_reset(2);
        rd_sr(8'h35);
        check(rd, 8'h02);
        wr_sr(8'h01, 8'h80);
        wr_sr(8'h31, 8'h01);
        wr_sr(8'h01, 8'h1C);
        check({3'h0, region_guard}, 8'h00);
    endtask
    initial begin
        reset = 1'b1;
        array_busy = 1'b0;
        array_erasing = 1'b0;
        do_reset(12);
        t_reset_values();
        t_guard_write();
        t_config();
        t_array();
        t_program();
        t_lockdown();
        end_of_test();
    end
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
endmodule
